// ---- udc_dma_ctrl.sv ----
// usb device dma channel control with classic wishbone slave
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module udc_dma_ctrl (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic usb_reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] rx_eot_evt,
  input wire logic [2:0] rx_eot_odd,
  input wire logic [2:0] tx_done_evt,
  input wire logic [2:0] rx_dma_req,
  input wire logic [2:0] tx_dma_req,
  input wire logic [15:0] rx_fifo_data,
  output logic [3:0] rx_fifo_ep,
  output logic rx_fifo_pop,
  output logic [3:0] tx_fifo_ep,
  output logic tx_fifo_push,
  output logic [15:0] tx_fifo_data,
  output logic [2:0] rx_chan_en,
  output logic [2:0] tx_chan_en,
  output logic [2:0] tx_end_of_transfer_mode,
  output logic irq
);
  udc_pkg::udc_bus_t bus_q;
  logic [11:0] rx_channel_endpoint_select_q;
  logic [11:0] tx_channel_endpoint_select_q;
  logic [2:0] tx_eot_q;
  logic receive_event_flag_q;
  logic transmit_event_flag_q;
  logic rx_odd_byte_flag_q;
  logic [3:0] rx_dma_source_endpoint_q;
  logic [3:0] tx_dma_source_endpoint_q;
  logic [2:0] rx_pend_q;
  logic [2:0] rx_pend_odd_q;
  logic [2:0] tx_pend_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [15:0] tx_fifo_data_q;
  logic tx_fifo_push_q;
  logic rx_fifo_pop_q;
  logic req;
  logic wr;
  logic rd;
  logic clr_rx;
  logic clr_tx;
  logic [2:0] rx_all;
  logic [2:0] tx_all;
  logic [1:0] rx_pick;
  logic [1:0] tx_pick;
  logic [15:0] stat_word;
  logic [2:0] rx_odd_all;

  function automatic logic [3:0] chan_ep(input logic [11:0] cfg,
                                         input logic [1:0] ch);
    chan_ep = cfg[4*ch +: 4];
  endfunction

  function automatic logic [1:0] first_set(input logic [2:0] v);
    if (v[0]) begin
      first_set = 2'd0;
    end else if (v[1]) begin
      first_set = 2'd1;
    end else begin
      first_set = 2'd2;
    end
  endfunction

  assign req = wb_cyc_i && wb_stb_i && (bus_q == udc_pkg::UDC_IDLE);
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign wb_ack_o = (bus_q == udc_pkg::UDC_ACK);

  // channel enables follow selectors immediately
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rx_chan_en[i] = chan_ep(rx_channel_endpoint_select_q, 2'(i))
                      != udc_pkg::EP_NONE;
      tx_chan_en[i] = chan_ep(tx_channel_endpoint_select_q, 2'(i))
                      != udc_pkg::EP_NONE;
    end
  end

  assign rx_pick = first_set(rx_dma_req & rx_chan_en);
  assign tx_pick = first_set(tx_dma_req & tx_chan_en);
  // data port steering by direction
  assign rx_fifo_ep = (|(rx_dma_req & rx_chan_en)) ?
    chan_ep(rx_channel_endpoint_select_q, rx_pick) : udc_pkg::EP_NONE;
  assign tx_fifo_ep = (|(tx_dma_req & tx_chan_en)) ?
    chan_ep(tx_channel_endpoint_select_q, tx_pick) : udc_pkg::EP_NONE;
  assign tx_fifo_push = tx_fifo_push_q;
  assign tx_fifo_data = tx_fifo_data_q;
  assign rx_fifo_pop = rx_fifo_pop_q;
  assign tx_end_of_transfer_mode = tx_eot_q;

  assign stat_word = {3'b000, rx_odd_byte_flag_q, rx_dma_source_endpoint_q,
                      4'h0, tx_dma_source_endpoint_q};
  assign clr_rx = wr && wb_adr_i == udc_pkg::ADDR_IRQ_STAT
                  && wb_dat_i[udc_pkg::IRQ_RX];
  assign clr_tx = wr && wb_adr_i == udc_pkg::ADDR_IRQ_STAT
                  && wb_dat_i[udc_pkg::IRQ_TX];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_q <= udc_pkg::UDC_IDLE;
    end else begin
      case (bus_q)
        udc_pkg::UDC_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            bus_q <= udc_pkg::UDC_ACK;
          end
        end
        default: begin
          bus_q <= udc_pkg::UDC_IDLE;
        end
      endcase
    end
  end

  // read data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      if (wb_adr_i == udc_pkg::ADDR_DMA_STAT) begin
        wb_dat_o <= {16'h0000, stat_word};
      end else if (wb_adr_i == udc_pkg::ADDR_RX_CFG) begin
        wb_dat_o <= {20'h00000, rx_channel_endpoint_select_q};
      end else if (wb_adr_i == udc_pkg::ADDR_TX_CFG) begin
        wb_dat_o <= {20'h00000, tx_channel_endpoint_select_q};
      end else if (wb_adr_i == udc_pkg::ADDR_DATA) begin
        wb_dat_o <= {16'h0000, rx_fifo_data};
      end else if (wb_adr_i == udc_pkg::ADDR_TX_CTL0) begin
        wb_dat_o <= {16'h0000, tx_eot_q[0], 15'h0000};
      end else if (wb_adr_i == udc_pkg::ADDR_TX_CTL1) begin
        wb_dat_o <= {16'h0000, tx_eot_q[1], 15'h0000};
      end else if (wb_adr_i == udc_pkg::ADDR_TX_CTL2) begin
        wb_dat_o <= {16'h0000, tx_eot_q[2], 15'h0000};
      end else if (wb_adr_i == udc_pkg::ADDR_IRQ_STAT) begin
        wb_dat_o <= {30'h00000000, irq_stat_q};
      end else if (wb_adr_i == udc_pkg::ADDR_IRQ_MASK) begin
        wb_dat_o <= {30'h00000000, irq_mask_q};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // data port strobes, one cycle each
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_fifo_push_q <= 1'b0;
      tx_fifo_data_q <= udc_pkg::RESET_16;
      rx_fifo_pop_q <= 1'b0;
    end else begin
      tx_fifo_push_q <= wr && wb_adr_i == udc_pkg::ADDR_DATA
                        && (|(tx_dma_req & tx_chan_en));
      rx_fifo_pop_q <= rd && wb_adr_i == udc_pkg::ADDR_DATA
                       && (|(rx_dma_req & rx_chan_en));
      if (wr && wb_adr_i == udc_pkg::ADDR_DATA) begin
        tx_fifo_data_q <= wb_dat_i[15:0];
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_channel_endpoint_select_q <= 12'h000;
      tx_channel_endpoint_select_q <= 12'h000;
      tx_eot_q <= 3'b000;
      irq_mask_q <= 2'b00;
    end else if (usb_reset) begin
      rx_channel_endpoint_select_q <= 12'h000;
      tx_channel_endpoint_select_q <= 12'h000;
      tx_eot_q <= 3'b000;
    end else if (wr) begin
      if (wb_adr_i == udc_pkg::ADDR_RX_CFG) begin
        rx_channel_endpoint_select_q <= wb_dat_i[11:0] & udc_pkg::CFG_MASK;
      end else if (wb_adr_i == udc_pkg::ADDR_TX_CFG) begin
        tx_channel_endpoint_select_q <= wb_dat_i[11:0] & udc_pkg::CFG_MASK;
      end else if (wb_adr_i == udc_pkg::ADDR_TX_CTL0) begin
        tx_eot_q[0] <= wb_dat_i[udc_pkg::TX_EOT_BIT];
      end else if (wb_adr_i == udc_pkg::ADDR_TX_CTL1) begin
        tx_eot_q[1] <= wb_dat_i[udc_pkg::TX_EOT_BIT];
      end else if (wb_adr_i == udc_pkg::ADDR_TX_CTL2) begin
        tx_eot_q[2] <= wb_dat_i[udc_pkg::TX_EOT_BIT];
      end else if (wb_adr_i == udc_pkg::ADDR_IRQ_MASK) begin
        irq_mask_q <= wb_dat_i[1:0];
      end
    end
  end

  // rx event tracking, pending events wait for the flag to clear
  assign rx_all = rx_pend_q | rx_eot_evt;
  assign tx_all = tx_pend_q | tx_done_evt;
  // latest odd qualifier per channel, a fresh event replaces a queued one
  assign rx_odd_all = (rx_pend_odd_q & ~rx_eot_evt)
                      | (rx_eot_odd & rx_eot_evt);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      receive_event_flag_q <= 1'b0;
      rx_odd_byte_flag_q <= 1'b0;
      rx_dma_source_endpoint_q <= 4'h0;
      rx_pend_q <= 3'b000;
      rx_pend_odd_q <= 3'b000;
    end else if (usb_reset) begin
      receive_event_flag_q <= 1'b0;
      rx_odd_byte_flag_q <= 1'b0;
      rx_dma_source_endpoint_q <= 4'h0;
      rx_pend_q <= 3'b000;
      rx_pend_odd_q <= 3'b000;
    end else if (!receive_event_flag_q && (|rx_all)) begin
      receive_event_flag_q <= 1'b1;
      rx_dma_source_endpoint_q <= chan_ep(rx_channel_endpoint_select_q,
                                          first_set(rx_all));
      rx_odd_byte_flag_q <= rx_odd_all[first_set(rx_all)];
      rx_pend_q <= rx_all & ~(3'b001 << first_set(rx_all));
      rx_pend_odd_q <= rx_odd_all & ~(3'b001 << first_set(rx_all));
    end else begin
      rx_pend_q <= rx_all;
      rx_pend_odd_q <= rx_odd_all & rx_all;
      if (clr_rx) begin
        receive_event_flag_q <= 1'b0;
        rx_odd_byte_flag_q <= 1'b0;
        rx_dma_source_endpoint_q <= 4'h0;
      end
    end
  end

  // tx event tracking
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      transmit_event_flag_q <= 1'b0;
      tx_dma_source_endpoint_q <= 4'h0;
      tx_pend_q <= 3'b000;
    end else if (usb_reset) begin
      transmit_event_flag_q <= 1'b0;
      tx_dma_source_endpoint_q <= 4'h0;
      tx_pend_q <= 3'b000;
    end else if (!transmit_event_flag_q && (|tx_all)) begin
      transmit_event_flag_q <= 1'b1;
      tx_dma_source_endpoint_q <= chan_ep(tx_channel_endpoint_select_q,
                                          first_set(tx_all));
      tx_pend_q <= tx_all & ~(3'b001 << first_set(tx_all));
    end else begin
      tx_pend_q <= tx_all;
      if (clr_tx) begin
        transmit_event_flag_q <= 1'b0;
        tx_dma_source_endpoint_q <= 4'h0;
      end
    end
  end

  // sticky interrupt bits mirror the event flags; clear beats a new event, which stays pending and sets the flag a cycle later
  assign irq_stat_q = {transmit_event_flag_q, receive_event_flag_q};
  assign irq = |(irq_stat_q & irq_mask_q);

  a_odd_needs_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_odd_byte_flag_q |-> receive_event_flag_q)
    else $error("odd flag without rx flag");
  a_rx_src_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !receive_event_flag_q |-> rx_dma_source_endpoint_q == 4'h0)
    else $error("rx source not zero");
  a_tx_src_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !transmit_event_flag_q |-> tx_dma_source_endpoint_q == 4'h0)
    else $error("tx source not zero");
  a_usb_reset_clr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    usb_reset |=> stat_word == 16'h0000
    && rx_channel_endpoint_select_q == 12'h000)
    else $error("usb reset did not clear");
  a_rx_cfg_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr && wb_adr_i == udc_pkg::ADDR_RX_CFG && !usb_reset
    |=> rx_channel_endpoint_select_q == $past(wb_dat_i[11:0]))
    else $error("rx cfg not stored");
  a_tx_cfg_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr && wb_adr_i == udc_pkg::ADDR_TX_CFG && !usb_reset
    |=> tx_channel_endpoint_select_q == $past(wb_dat_i[11:0]))
    else $error("tx cfg not stored");
  a_rx_chan_en: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_chan_en[0] == (rx_channel_endpoint_select_q[3:0] != 4'h0))
    else $error("rx enable mismatch");
  a_tx_chan_en: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_chan_en[2] == (tx_channel_endpoint_select_q[11:8] != 4'h0))
    else $error("tx enable mismatch");
  a_push_port: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_fifo_push |-> $past(wr && wb_adr_i == udc_pkg::ADDR_DATA
    && tx_fifo_ep != 4'h0))
    else $error("push without tx request");
  a_rx_src_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    receive_event_flag_q && !clr_rx && !usb_reset
    |=> $stable(rx_dma_source_endpoint_q))
    else $error("rx source changed while pending");
  a_tx_eot_bit: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr && wb_adr_i == udc_pkg::ADDR_TX_CTL0 && !usb_reset
    |=> tx_end_of_transfer_mode[0] == $past(wb_dat_i[15]))
    else $error("tx eot bit not stored");
  a_ack_one: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req |=> wb_ack_o)
    else $error("request not acknowledged");
  a_pop_port: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_fifo_pop |-> $past(rd && wb_adr_i == udc_pkg::ADDR_DATA
    && rx_fifo_ep != 4'h0))
    else $error("pop without rx request");
  a_odd_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !receive_event_flag_q && rx_eot_evt[0] && rx_eot_odd[0] && !usb_reset
    |=> receive_event_flag_q && rx_odd_byte_flag_q)
    else $error("odd flag not set");
  a_odd_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
    receive_event_flag_q && clr_rx && !usb_reset
    |=> !receive_event_flag_q && !rx_odd_byte_flag_q)
    else $error("odd flag survived clear");
  a_rx_src_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !receive_event_flag_q && rx_eot_evt[0] && !usb_reset
    |=> rx_dma_source_endpoint_q == $past(rx_channel_endpoint_select_q[3:0]))
    else $error("rx source not loaded");
  a_tx_src_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !transmit_event_flag_q && tx_done_evt[0] && !usb_reset
    |=> tx_dma_source_endpoint_q == $past(tx_channel_endpoint_select_q[3:0]))
    else $error("tx source not loaded");
  a_rx_steer: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_dma_req[0] && rx_chan_en[0]
    |-> rx_fifo_ep == rx_channel_endpoint_select_q[3:0])
    else $error("rx port steered wrong");
  a_tx_steer: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_dma_req[0] && tx_chan_en[0]
    |-> tx_fifo_ep == tx_channel_endpoint_select_q[3:0])
    else $error("tx port steered wrong");
  a_tx_src_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    transmit_event_flag_q && !clr_tx && !usb_reset
    |=> $stable(tx_dma_source_endpoint_q))
    else $error("tx source changed while pending");
  a_usb_reset_tx: assert property (@(posedge sys_clk) disable iff (!arst_n)
    usb_reset |=> tx_channel_endpoint_select_q == 12'h000
    && tx_end_of_transfer_mode == 3'b000 && !irq)
    else $error("usb reset left tx state");
  a_rx_cfg_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(wr && wb_adr_i == udc_pkg::ADDR_RX_CFG) && !usb_reset
    |=> $stable(rx_channel_endpoint_select_q))
    else $error("rx cfg changed without write");
  a_stat_rsvd: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rd && wb_adr_i == udc_pkg::ADDR_DMA_STAT
    |=> wb_dat_o[31:13] == 19'h00000 && wb_dat_o[7:4] == 4'h0)
    else $error("status reserved bits set");
  a_cfg_rsvd: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rd && wb_adr_i == udc_pkg::ADDR_TX_CFG
    |=> wb_dat_o[31:12] == 20'h00000)
    else $error("cfg reserved bits set");
  c_rx_event: cover property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(receive_event_flag_q) && rx_odd_byte_flag_q);
  c_both_req: cover property (@(posedge sys_clk) disable iff (!arst_n)
    rx_fifo_pop_q && (|tx_dma_req));
  c_rx_queued: cover property (@(posedge sys_clk) disable iff (!arst_n)
    receive_event_flag_q && (|rx_pend_q));
  c_tx_queued: cover property (@(posedge sys_clk) disable iff (!arst_n)
    transmit_event_flag_q && (|tx_pend_q));
  c_usb_reset: cover property (@(posedge sys_clk) disable iff (!arst_n)
    usb_reset && transmit_event_flag_q);
endmodule
`default_nettype wire

// ---- udc_dma_ctrl_tb_top.sv ----
// self-checking bench for the usb dma channel control block
`timescale 1ns/100ps
`default_nettype none
module udc_dma_ctrl_tb_top;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic usb_reset = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r, rdata;
  logic wb_ack, rx_fifo_pop, tx_fifo_push, irq;
  logic [2:0] rx_eot_evt = 3'h0;
  logic [2:0] rx_eot_odd = 3'h0;
  logic [2:0] tx_done_evt = 3'h0;
  logic [2:0] rx_dma_req = 3'h0;
  logic [2:0] tx_dma_req = 3'h0;
  logic [2:0] rx_chan_en, tx_chan_en, tx_eot_mode;
  logic [3:0] rx_fifo_ep, tx_fifo_ep, push_ep;
  logic [15:0] rx_fifo_data, tx_fifo_data, push_data;
  logic [71:0] rows [8];
  int n_fail = 0;
  int checks_done = 0;

  always #2.5 sys_clk = ~sys_clk;

  udc_dma_ctrl udc_dma_ctrl_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .usb_reset(usb_reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .rx_eot_evt(rx_eot_evt), .rx_eot_odd(rx_eot_odd),
    .tx_done_evt(tx_done_evt), .rx_dma_req(rx_dma_req),
    .tx_dma_req(tx_dma_req), .rx_fifo_data(rx_fifo_data),
    .rx_fifo_ep(rx_fifo_ep), .rx_fifo_pop(rx_fifo_pop),
    .tx_fifo_ep(tx_fifo_ep), .tx_fifo_push(tx_fifo_push),
    .tx_fifo_data(tx_fifo_data), .rx_chan_en(rx_chan_en),
    .tx_chan_en(tx_chan_en), .tx_end_of_transfer_mode(tx_eot_mode),
    .irq(irq));

  udc_dma_partner udc_dma_partner_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .rx_fifo_ep(rx_fifo_ep), .rx_fifo_pop(rx_fifo_pop),
    .tx_fifo_ep(tx_fifo_ep), .tx_fifo_push(tx_fifo_push),
    .tx_fifo_data(tx_fifo_data), .rx_fifo_data(rx_fifo_data),
    .push_data_q(push_data), .push_ep_q(push_ep));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic single cycle, held until ack, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] d);
    int i;
    i = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= d;
    do begin
      @(posedge sys_clk);
      i++;
    end while (wb_ack !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_fail++;
      end_of_test();
    end
    rdata = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(rdata, exp);
  endtask

  task automatic ev(input logic [2:0] rx, input logic [2:0] odd,
                    input logic [2:0] tx);
    rx_eot_evt <= rx;
    rx_eot_odd <= odd;
    tx_done_evt <= tx;
    @(posedge sys_clk);
    rx_eot_evt <= 3'h0;
    rx_eot_odd <= 3'h0;
    tx_done_evt <= 3'h0;
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    rows[0] = {udc_pkg::ADDR_RX_CFG, 32'hffff_ffff, 32'h0000_0fff};
    rows[1] = {udc_pkg::ADDR_TX_CFG, 32'h0000_a5c3, 32'h0000_05c3};
    rows[2] = {udc_pkg::ADDR_TX_CTL0, 32'h0000_ffff, 32'h0000_8000};
    rows[3] = {udc_pkg::ADDR_TX_CTL1, 32'h0000_8000, 32'h0000_8000};
    rows[4] = {udc_pkg::ADDR_TX_CTL2, 32'h0000_7fff, 32'h0000_0000};
    rows[5] = {udc_pkg::ADDR_DMA_STAT, 32'h0000_ffff, 32'h0000_0000};
    rows[6] = {8'h40, 32'hffff_ffff, 32'h0000_0000};
    rows[7] = {udc_pkg::ADDR_IRQ_MASK, 32'h0000_0003, 32'h0000_0003};
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(udc_pkg::ADDR_DMA_STAT, 32'h0);
    foreach (rows[k]) begin
      wb(1'b1, rows[k][71:64], rows[k][63:32]);
      rd_chk(rows[k][71:64], rows[k][31:0]);
    end
    check(32'(tx_eot_mode), 32'h3);
    check(32'({rx_chan_en, tx_chan_en}), 32'h3f);
    // channels rebound, rx channel 1 and tx channel 1 left unbound
    wb(1'b1, udc_pkg::ADDR_RX_CFG, 32'h0000_0305);
    wb(1'b1, udc_pkg::ADDR_TX_CFG, 32'h0000_0a07);
    check(32'({rx_chan_en, tx_chan_en}), 32'h2d);
    rx_dma_req <= 3'b100;
    tx_dma_req <= 3'b001;
    @(posedge sys_clk);
    check(32'({rx_fifo_ep, tx_fifo_ep}), 32'h37);
    rd_chk(udc_pkg::ADDR_DATA, 32'h0000_3000);
    wb(1'b1, udc_pkg::ADDR_DATA, 32'h0000_beef);
    repeat (2) @(posedge sys_clk);
    check(32'({push_ep, push_data}), 32'h7_beef);
    rd_chk(udc_pkg::ADDR_DATA, 32'h0000_3001);
    tx_dma_req <= 3'b000;
    @(posedge sys_clk);
    wb(1'b1, udc_pkg::ADDR_DATA, 32'h0000_1234);
    repeat (2) @(posedge sys_clk);
    check(32'(push_data), 32'hbeef);
    check(32'(tx_fifo_data), 32'h1234);
    rx_dma_req <= 3'b000;
    ev(3'b100, 3'b100, 3'b001);
    rd_chk(udc_pkg::ADDR_DMA_STAT, 32'h1307);
    check(32'(irq), 32'h1);
    ev(3'b001, 3'b000, 3'b000);
    rd_chk(udc_pkg::ADDR_DMA_STAT, 32'h1307);
    wb(1'b1, udc_pkg::ADDR_IRQ_STAT, 32'h1);
    rd_chk(udc_pkg::ADDR_DMA_STAT, 32'h0507);
    wb(1'b1, udc_pkg::ADDR_IRQ_STAT, 32'h3);
    rd_chk(udc_pkg::ADDR_DMA_STAT, 32'h0);
    check(32'(irq), 32'h0);
    wb(1'b1, udc_pkg::ADDR_IRQ_MASK, 32'h0);
    ev(3'b000, 3'b000, 3'b100);
    rd_chk(udc_pkg::ADDR_DMA_STAT, 32'h000a);
    check(32'(irq), 32'h0);
    wb(1'b1, udc_pkg::ADDR_IRQ_MASK, 32'h2);
    check(32'(irq), 32'h1);
    usb_reset <= 1'b1;
    @(posedge sys_clk);
    usb_reset <= 1'b0;
    @(posedge sys_clk);
    rd_chk(udc_pkg::ADDR_DMA_STAT, 32'h0);
    rd_chk(udc_pkg::ADDR_RX_CFG, 32'h0);
    rd_chk(udc_pkg::ADDR_TX_CFG, 32'h0);
    check(32'({irq, tx_eot_mode, tx_chan_en}), 32'h0);
    wb(1'b1, udc_pkg::ADDR_RX_CFG, 32'h0000_0fff);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(32'(rx_chan_en), 32'h0);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(udc_pkg::ADDR_RX_CFG, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- udc_dma_partner.sv ----
// system dma side model: endpoint fifo source and push sink
`timescale 1ns/100ps
`default_nettype none
module udc_dma_partner (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] rx_fifo_ep,
  input wire logic rx_fifo_pop,
  input wire logic [3:0] tx_fifo_ep,
  input wire logic tx_fifo_push,
  input wire logic [15:0] tx_fifo_data,
  output logic [15:0] rx_fifo_data,
  output logic [15:0] push_data_q,
  output logic [3:0] push_ep_q
);
  logic [11:0] pop_cnt_q;
  // word differs per endpoint and per pop
  assign rx_fifo_data = {rx_fifo_ep, pop_cnt_q};
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pop_cnt_q <= 12'h000;
      push_data_q <= 16'h0000;
      push_ep_q <= 4'h0;
    end else begin
      if (rx_fifo_pop) begin
        pop_cnt_q <= pop_cnt_q + 12'h001;
      end
      if (tx_fifo_push) begin
        push_data_q <= tx_fifo_data;
        push_ep_q <= tx_fifo_ep;
      end
    end
  end
endmodule
`default_nettype wire

// ---- udc_pkg.sv ----
// package: register map, field layout and states of the usb dma channel block
package udc_pkg;
  localparam logic [7:0] ADDR_DMA_STAT = 8'h00;
  localparam logic [7:0] ADDR_RX_CFG = 8'h04;
  localparam logic [7:0] ADDR_TX_CFG = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_TX_CTL0 = 8'h10;
  localparam logic [7:0] ADDR_TX_CTL1 = 8'h14;
  localparam logic [7:0] ADDR_TX_CTL2 = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam int ODD_BIT = 12;
  localparam int RX_SRC_LSB = 8;
  localparam int TX_SRC_LSB = 0;
  localparam int TX_EOT_BIT = 15;
  localparam logic [11:0] CFG_MASK = 12'hfff;
  localparam logic [15:0] RESET_16 = 16'h0000;
  localparam logic [3:0] EP_NONE = 4'h0;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  typedef enum logic [1:0] {
    UDC_IDLE = 2'b00,
    UDC_ACK = 2'b01
  } udc_bus_t;
endpackage
